// file: inc/usart_flow_defs.svh
/*
 * constants of the serial receive block: reset values, field positions and ratios.
 * assumes it is included by bare name, after which the macros are global.
 */
`ifndef USART_FLOW_DEFS_SVH
`define USART_FLOW_DEFS_SVH

`define CLK_RATIO_MIN 9
`define CHAR_LEN_DEFAULT 4'h8
`define CHAR_LEN_MIN 4'h5
`define RTS_RESET 1'h0
`define ERR_COUNT_READ 8'h00
`define STAT_OVL_ERR 0
`define STAT_OVERRUN 1
`define STAT_RX_BLOCKED 2

`endif

// file: inc/usart_flow_pkg.sv
/*
 * types shared by the serial receive block and its users.
 * assumes usart_flow_defs.svh supplies the numeric constants.
 */
package usart_flow_pkg;

    typedef enum logic [1:0] {
        mode_normal,
        mode_handshake,
        mode_spi_slave,
        mode_smartcard_t1
    } usart_mode_type;

    typedef struct packed {
        logic rx_blocked;
        logic overrun;
        logic ovl_err;
    } status_type;

    typedef struct packed {
        logic flow_force_high_cmd;
        logic flow_force_low_cmd;
        logic rx_soft_reset;
        logic ovl_err_clear;
        logic overrun_clear;
    } command_control_type;

endpackage : usart_flow_pkg

// file: verilog/rx_word_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides and flags decoded from the registered count.
 * assumes one clock, synchronous active-low reset, DEPTH a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module rx_word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
        $error("rx_word_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage carries no reset: contents are qualified by count
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule : rx_word_fifo
`default_nettype wire

// file: verilog/usart_flow_rx.sv
/*
 * serial receiver with request-to-send flow control, slave clocking,
 * over-length detection in spi slave mode and smart-card T1 receive lock.
 * assumes the serial clock, data and select pins are asynchronous to mclk_i,
 * and that command inputs are single-cycle pulses from logic on mclk_i.
 */
`timescale 1ns/1ns
`default_nettype none
`include "usart_flow_defs.svh"
module usart_flow_rx #(
    parameter int DATA_W = 9,
    parameter int FIFO_DEPTH = 32,
    parameter bit AFFECTED_REV = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire usart_flow_pkg::usart_mode_type mode_config_reg_i,
    input wire logic [3:0] char_len_i,
    input wire usart_flow_pkg::command_control_type command_control_reg_i,
    input wire logic mode_write_i,
    input wire logic control_write_i,
    input wire logic dma_rx_full_i,
    input wire logic tx_done_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic spi_select_n_i,
    output logic rts_o,
    output usart_flow_pkg::status_type status_o,
    output logic [7:0] smartcard_error_count_o,
    output logic [DATA_W-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i
);
    if (DATA_W < 5 || DATA_W > 9 || FIFO_DEPTH < 2) begin : g_bad_params
        $error("usart_flow_rx: DATA_W must be 5..9, FIFO_DEPTH >= 2");
    end

    typedef enum logic [1:0] {
        lock_open,
        lock_blocked,
        lock_wait_mode,
        lock_wait_ctrl
    } lock_state_type;

    // three-stage synchronisers: ff1 only feeds ff2
    logic [2:0] clk_sync, dat_sync, sel_sync;
    logic clk_lvl, next_clk_lvl, sel_lvl, next_sel_lvl;
    logic clk_rise, sel_rise;

    logic rts, next_rts;
    logic [DATA_W-1:0] shift, next_shift;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic push_valid, next_push_valid;
    logic [DATA_W-1:0] push_data, next_push_data;
    logic fifo_ready;
    logic ovl_err, next_ovl_err, overrun, next_overrun;
    lock_state_type lock, next_lock;
    logic [DATA_W-1:0] fifo_data;
    logic fifo_valid;
    logic [DATA_W-1:0] out_data, next_out_data;
    logic out_valid, next_out_valid;
    logic fifo_pop;
    logic ovl_event, overrun_event;
    logic [4:0] len;
    logic [DATA_W-1:0] len_mask;
    logic rx_blocked, next_rx_blocked;

    // valid only while the serial clock is at least nine mclk periods long,
    // so every level survives the two agreeing stages
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            clk_sync <= 3'h0;
            dat_sync <= 3'h0;
            sel_sync <= 3'h7;
        end else begin
            clk_sync <= {clk_sync[1:0], serial_clk_i};
            dat_sync <= {dat_sync[1:0], serial_data_i};
            sel_sync <= {sel_sync[1:0], spi_select_n_i};
        end
    end

    always_comb begin
        next_clk_lvl = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_lvl;
        next_sel_lvl = (sel_sync[1] == sel_sync[2]) ? sel_sync[2] : sel_lvl;
    end

    assign clk_rise = next_clk_lvl && !clk_lvl;
    assign sel_rise = next_sel_lvl && !sel_lvl;
    assign len = {1'b0, char_len_i};

    // bits above the character would otherwise carry the previous frame's tail
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_len_mask
        assign len_mask[gi] = (5'(gi) < len);
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            clk_lvl <= 1'b0;
            sel_lvl <= 1'b1;
        end else begin
            clk_lvl <= next_clk_lvl;
            sel_lvl <= next_sel_lvl;
        end
    end

    // request-to-send
    always_comb begin
        next_rts = rts;
        if (mode_config_reg_i == usart_flow_pkg::mode_handshake) begin
            // affected silicon never raises the line in this mode
            next_rts = AFFECTED_REV ? 1'b0 : dma_rx_full_i;
        end else if (command_control_reg_i.flow_force_high_cmd) begin
            next_rts = 1'b1;
        end else if (command_control_reg_i.flow_force_low_cmd) begin
            next_rts = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rts <= `RTS_RESET;
        end else begin
            rts <= next_rts;
        end
    end

    // T1 receive lock: reset, then mode rewrite, then control rewrite
    always_comb begin
        next_lock = lock;
        case (lock)
            lock_open: begin
                if (mode_config_reg_i == usart_flow_pkg::mode_smartcard_t1 && tx_done_i) begin
                    next_lock = lock_blocked;
                end
            end
            lock_blocked: begin
                if (command_control_reg_i.rx_soft_reset) begin
                    next_lock = lock_wait_mode;
                end
            end
            lock_wait_mode: begin
                if (mode_write_i) begin
                    next_lock = lock_wait_ctrl;
                end
            end
            lock_wait_ctrl: begin
                if (control_write_i) begin
                    next_lock = lock_open;
                end
            end
            default: next_lock = lock_open;
        endcase
        next_rx_blocked = (next_lock != lock_open);
    end

    // shift and frame
    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_push_valid = push_valid && !fifo_ready;
        next_push_data = push_data;
        ovl_event = 1'b0;
        overrun_event = 1'b0;
        if (command_control_reg_i.rx_soft_reset || lock != lock_open) begin
            next_bit_cnt = 5'h00;
        end else if (mode_config_reg_i == usart_flow_pkg::mode_spi_slave) begin
            if (sel_rise) begin
                if (bit_cnt > len) begin
                    ovl_event = 1'b1; // frame too long: dropped
                end else if (bit_cnt == len) begin
                    overrun_event = next_push_valid;
                    next_push_valid = 1'b1;
                    next_push_data = shift & len_mask;
                end
                next_bit_cnt = 5'h00;
            end else if (!sel_lvl && clk_rise) begin
                next_shift = {shift[DATA_W-2:0], dat_sync[2]};
                // saturating so any length beyond the character is seen
                next_bit_cnt = (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'h01;
            end
        end else if (clk_rise) begin
            next_shift = {shift[DATA_W-2:0], dat_sync[2]};
            if (bit_cnt + 5'h01 == len) begin
                overrun_event = next_push_valid;
                next_push_valid = 1'b1;
                next_push_data = {shift[DATA_W-2:0], dat_sync[2]} & len_mask;
                next_bit_cnt = 5'h00;
            end else begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end
        // an event in the clear cycle wins over the clear
        next_ovl_err = ovl_event || (ovl_err && !command_control_reg_i.ovl_err_clear);
        next_overrun = overrun_event || (overrun && !command_control_reg_i.overrun_clear);
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            shift <= '0;
            bit_cnt <= 5'h00;
            push_valid <= 1'b0;
            push_data <= '0;
            ovl_err <= 1'b0;
            overrun <= 1'b0;
            lock <= lock_open;
            rx_blocked <= 1'b0;
        end else begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            push_valid <= next_push_valid;
            push_data <= next_push_data;
            ovl_err <= next_ovl_err;
            overrun <= next_overrun;
            lock <= next_lock;
            rx_blocked <= next_rx_blocked;
        end
    end

    rx_word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_data_i(push_data),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );

    // output stage keeps rx data on a flop; costs one cycle of latency
    assign fifo_pop = fifo_valid && (!out_valid || rx_ready_i);

    always_comb begin
        next_out_valid = out_valid && !rx_ready_i;
        next_out_data = out_data;
        if (fifo_pop) begin
            next_out_valid = 1'b1;
            next_out_data = fifo_data;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    assign rts_o = rts;
    assign rx_valid_o = out_valid;
    assign rx_data_o = out_data;
    assign status_o = {rx_blocked, overrun, ovl_err};
    // affected silicon never reports a count
    assign smartcard_error_count_o = `ERR_COUNT_READ;
endmodule : usart_flow_rx
`default_nettype wire

// file: dv/usart_flow_rx_properties.sv
/* port checker of the serial receive block.
   assumes bind onto usart_flow_rx, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module usart_flow_rx_properties #(
    parameter int DATA_W = 9,
    parameter bit AFFECTED_REV = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire usart_flow_pkg::usart_mode_type mode_config_reg_i,
    input wire usart_flow_pkg::command_control_type command_control_reg_i,
    input wire logic mode_write_i,
    input wire logic control_write_i,
    input wire logic tx_done_i,
    input wire logic rts_o,
    input wire usart_flow_pkg::status_type status_o,
    input wire logic [7:0] smartcard_error_count_o,
    input wire logic [DATA_W-1:0] rx_data_o,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic hs;
    assign hs = mode_config_reg_i == usart_flow_pkg::mode_handshake;
    // unlock steps must come in this order
    sequence s_unlock;
        command_control_reg_i.rx_soft_reset ##[1:8] mode_write_i ##[1:8] control_write_i;
    endsequence
    AST_HS_RTS_LOW: assert property (AFFECTED_REV && hs |=> !rts_o)
        else $error("rts high in handshake mode");
    AST_FORCE_HIGH: assert property (command_control_reg_i.flow_force_high_cmd && !hs |=> rts_o)
        else $error("force high did not raise rts");
    AST_RTS_STANDS: assert property (rts_o && !command_control_reg_i.flow_force_low_cmd && !hs |=> rts_o)
        else $error("rts dropped without command");
    AST_FORCE_LOW: assert property (command_control_reg_i.flow_force_low_cmd
        && !command_control_reg_i.flow_force_high_cmd && !hs |=> !rts_o)
        else $error("force low did not lower rts");
    AST_OVL_SPI: assert property ($rose(status_o.ovl_err) |-> mode_config_reg_i == usart_flow_pkg::mode_spi_slave)
        else $error("over-length flag outside spi mode");
    AST_ERR_COUNT: assert property (smartcard_error_count_o == 8'h00)
        else $error("error count not zero");
    AST_T1_LOCK: assert property (mode_config_reg_i == usart_flow_pkg::mode_smartcard_t1 && tx_done_i
        |=> status_o.rx_blocked)
        else $error("no receive lock after transmit");
    AST_LOCK_HOLD: assert property (status_o.rx_blocked && !control_write_i |=> status_o.rx_blocked)
        else $error("lock released early");
    AST_UNLOCK: assert property (status_o.rx_blocked ##0 s_unlock |=> !status_o.rx_blocked)
        else $error("lock not released");
    AST_OVL_STICKY: assert property (status_o.ovl_err && !command_control_reg_i.ovl_err_clear
        |=> status_o.ovl_err)
        else $error("over-length flag lost");
    AST_VALID_HOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("output word changed while stalled");
endmodule : usart_flow_rx_properties
bind usart_flow_rx usart_flow_rx_properties #(.DATA_W(DATA_W), .AFFECTED_REV(AFFECTED_REV))
    u_usart_flow_rx_properties (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_config_reg_i(mode_config_reg_i),
    .command_control_reg_i(command_control_reg_i), .mode_write_i(mode_write_i),
    .control_write_i(control_write_i), .tx_done_i(tx_done_i), .rts_o(rts_o), .status_o(status_o),
    .smartcard_error_count_o(smartcard_error_count_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i));
`default_nettype wire

// file: dv/serial_peer_model.sv
/* serial master peer: clock, data and select of the receiver.
   assumes the bench calls send_frame; clock idles low between frames. */
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
    input wire logic mclk_i,
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic spi_select_n_o
);
    initial begin
        serial_clk_o = 1'h0;
        serial_data_o = 1'h0;
        spi_select_n_o = 1'h1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : hold
    // ten mclk per half period leaves margin over nine for synchroniser jitter
    task automatic send_frame(input logic [15:0] bits, input int n, input bit spi);
        spi_select_n_o = !spi;
        hold(10);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o = bits[i];
            hold(10);
            serial_clk_o = 1'h1;
            hold(10);
            serial_clk_o = 1'h0;
        end
        // data no longer held: show the opposite level
        serial_data_o = !serial_data_o;
        hold(10);
        spi_select_n_o = 1'h1;
        hold(10);
    endtask : send_frame
endmodule : serial_peer_model
`default_nettype wire

// file: dv/tb_top.sv
/* self-checking bench of the serial receive block.
   assumes the peer model drives the pins and the checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic mclk_i = 1'h0;
    logic rstn_i = 1'h0;
    usart_flow_pkg::usart_mode_type mode = usart_flow_pkg::mode_normal;
    logic [3:0] char_len = 4'h8;
    usart_flow_pkg::command_control_type cmd = '0;
    logic mode_write = 1'h0;
    logic control_write = 1'h0;
    logic dma_full = 1'h0;
    logic tx_done = 1'h0;
    logic rx_ready = 1'h0;
    logic sclk;
    logic sdata;
    logic sel_n;
    logic rts;
    usart_flow_pkg::status_type status;
    logic [7:0] err_count;
    logic [8:0] rx_data;
    logic rx_valid;
    int n_fail = 0;
    int samples_checked = 0;
    int n;
    // mode, dma full, force high, force low, expected rts
    localparam logic [5:0] ROWS [0:6] = '{6'h05, 6'h02, 6'h07, 6'h1C, 6'h25, 6'h32, 6'h0D};
    always #2 mclk_i = ~mclk_i;
    usart_flow_rx u_usart_flow_rx (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_config_reg_i(mode),
        .char_len_i(char_len), .command_control_reg_i(cmd), .mode_write_i(mode_write),
        .control_write_i(control_write), .dma_rx_full_i(dma_full), .tx_done_i(tx_done),
        .serial_clk_i(sclk), .serial_data_i(sdata), .spi_select_n_i(sel_n), .rts_o(rts),
        .status_o(status), .smartcard_error_count_o(err_count), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready));
    serial_peer_model u_serial_peer_model (.mclk_i(mclk_i), .serial_clk_o(sclk),
        .serial_data_o(sdata), .spi_select_n_o(sel_n));
    task automatic step(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input logic [4:0] c);
        cmd = c;
        step(1);
        cmd = '0;
    endtask : pulse
    task automatic wait_valid();
        int k;
        k = 0;
        while (rx_valid !== 1'h1 && k < 400) begin
            step(1);
            k++;
        end
        if (k == 400) n_fail++;
    endtask : wait_valid
    task automatic pop();
        rx_ready = 1'h1;
        step(1);
        rx_ready = 1'h0;
    endtask : pop
    task automatic close_out();
        $display("mismatches=%0d checks=%0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    initial begin
        step(5);
        chk({rts, status, err_count, rx_valid}, 16'h0000);
        rstn_i = 1'h1;
        step(3);
        foreach (ROWS[i]) begin
            mode = usart_flow_pkg::usart_mode_type'(ROWS[i][5:4]);
            dma_full = ROWS[i][3];
            pulse({ROWS[i][2:1], 3'h0});
            chk(rts, ROWS[i][0]);
            step(1);
        end
        // reset in mid-run with rts high
        rstn_i = 1'h0;
        step(3);
        chk(rts, 1'h0);
        rstn_i = 1'h1;
        mode = usart_flow_pkg::mode_normal;
        dma_full = 1'h0;
        char_len = 4'h5;
        step(3);
        u_serial_peer_model.send_frame(16'h0013, 5, 1'b0);
        wait_valid();
        chk(rx_data, 16'h0013);
        pop();
        mode = usart_flow_pkg::mode_spi_slave;
        char_len = 4'h8;
        u_serial_peer_model.send_frame(16'h01A5, 9, 1'b1);
        step(20);
        chk({status.ovl_err, rx_valid, err_count}, 16'h0200);
        pulse(5'h02);
        chk(status.ovl_err, 1'h0);
        u_serial_peer_model.send_frame(16'h005A, 8, 1'b1);
        wait_valid();
        chk(rx_data, 16'h005A);
        pop();
        // fill the buffer with the consumer stalled until words are lost
        for (int i = 0; i < 36; i++) u_serial_peer_model.send_frame(16'(i), 8, 1'b1);
        chk(status.overrun, 1'h1);
        n = 0;
        while (rx_valid === 1'h1 && n < 40) begin
            if (n < 33) chk(rx_data, 16'(n));
            else chk(rx_data, 16'h0023);
            pop();
            step(3);
            n++;
        end
        chk(16'(n), 16'h0022);
        chk(rx_valid, 1'h0);
        pulse(5'h01);
        chk(status.overrun, 1'h0);
        mode = usart_flow_pkg::mode_smartcard_t1;
        tx_done = 1'h1;
        step(1);
        tx_done = 1'h0;
        chk(status.rx_blocked, 1'h1);
        u_serial_peer_model.send_frame(16'h0033, 8, 1'b0);
        step(10);
        chk({rx_valid, err_count}, 16'h0000);
        pulse(5'h04);
        mode_write = 1'h1;
        step(1);
        mode_write = 1'h0;
        control_write = 1'h1;
        step(1);
        control_write = 1'h0;
        step(1);
        chk(status.rx_blocked, 1'h0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
